// *** common/pc_flow_regs.vh ***
// Purpose: Register offsets, field positions and reset values of the
//          program-flow block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes:   Definitions only.
`ifndef PC_FLOW_REGS_VH
`define PC_FLOW_REGS_VH

`define REG_PC_LOW        8'h00
`define REG_PC_HIGH_LATCH 8'h04
`define REG_PC_FULL       8'h08
`define REG_STACK_PTR     8'h0C
`define REG_PWR_STATUS    8'h10
`define REG_CONFIG        8'h14
`define REG_PTR0          8'h18
`define REG_PTR1          8'h1C
`define REG_IND0          8'h20
`define REG_IND1          8'h24
`define REG_IRQ_STATUS    8'h28
`define REG_IRQ_CLEAR     8'h2C
`define REG_IRQ_ENABLE    8'h30
`define REG_WORKING       8'h34

`define PWR_OVF_BIT       0
`define PWR_UNF_BIT       1
`define CFG_FAULT_EN_BIT  0
`define IRQ_OVF_BIT       0
`define IRQ_UNF_BIT       1
`define IRQ_RESET_BIT     2

`define PC_RESET          15'h0000
`define PTR_RESET         16'h0000
`define CFG_RESET         1'b0
`define STACK_PTR_RESET   5'h1F

`define OP_NONE           3'h0
`define OP_CALL           3'h1
`define OP_CALL_WORKING   3'h2
`define OP_BRANCH_WORKING 3'h3
`define OP_BRANCH_IMM     3'h4
`define OP_RETURN         3'h5
`define OP_INTERRUPT      3'h6

// Address of the first indirect port, the second is the next address
`define IND_PORT0_ADDR    16'h0000
`define IND_PORT1_ADDR    16'h0001

`endif

// *** core/return_stack.v ***
// Purpose: Sixteen-level return address stack with wrap or fault reset.
// Assumes: At most one push or pop per cycle.
// Notes:   Pointer 5'h1F means empty; a push then lands in location 0.
`timescale 1ns/1ps
`include "pc_flow_regs.vh"

module return_stack #(
    parameter AW = 15,
    parameter DEPTH_LOG2 = 4
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Control
    input wire push,
    input wire pop,
    input wire fault_en,
    input wire [AW-1:0] push_data,
    // Results
    output wire [AW-1:0] top_data,
    output reg overflow,
    output reg underflow,
    output wire [DEPTH_LOG2:0] ptr
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [AW-1:0] mem_q [0:DEPTH-1];
    reg [DEPTH_LOG2:0] ptr_q;
    wire empty = ptr_q[DEPTH_LOG2];
    wire full = !ptr_q[DEPTH_LOG2] && (&ptr_q[DEPTH_LOG2-1:0]);
    wire [DEPTH_LOG2-1:0] wr_idx = ptr_q[DEPTH_LOG2-1:0] + 1'b1;

    assign ptr = ptr_q;
    assign top_data = mem_q[ptr_q[DEPTH_LOG2-1:0]];

    always @* begin
        overflow = push && full && fault_en;
        underflow = pop && empty && fault_en;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= `STACK_PTR_RESET;
        end else if (push && !(full && fault_en)) begin
            // Full stack without fault reset wraps onto location 0
            mem_q[wr_idx] <= push_data;
            ptr_q <= {1'b0, wr_idx};
        end else if (pop && !(empty && fault_en)) begin
            // Unchecked pop from empty wraps to the full position
            ptr_q <= empty ? {1'b0, {DEPTH_LOG2{1'b1}}} : ptr_q - 1'b1;
        end
    end
endmodule

// *** core/indirect_access.v ***
// Purpose: Indirect data access port driven by one file-select pointer.
// Assumes: Data memory is an external bus that answers combinationally.
// Notes:   Self-addressed indirect access reads zero, write suppressed.
`timescale 1ns/1ps
`include "pc_flow_regs.vh"

module indirect_access (
    // Pointer
    input wire [15:0] pointer,
    // Request
    input wire rd,
    input wire wr,
    input wire [7:0] wdata,
    // Data memory
    output reg [15:0] mem_addr,
    output reg mem_rd,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    // Result
    output reg [7:0] rdata
);
    wire self_hit = (pointer == `IND_PORT0_ADDR) ||
        (pointer == `IND_PORT1_ADDR);

    always @* begin
        mem_addr = pointer;
        mem_rd = rd && !self_hit;
        mem_wr = wr && !self_hit;
        mem_wdata = wdata;
        rdata = self_hit ? 8'h00 : mem_rdata;
    end
endmodule

// *** core/pc_flow.v ***
// Purpose: Program counter, return stack and indirect addressing
//          of an 8-bit core, with a Wishbone register slave.
// Assumes: One instruction per op_valid pulse; data memory answers
//          combinationally on mem_rdata.
// Notes:   Core reset request is a one-cycle pulse on core_reset_q.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pc_flow_regs.vh"

module pc_flow (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Instruction stream from decoder
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [10:0] op_operand,
    // Data memory
    output reg [15:0] mem_addr,
    output reg mem_rd,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    // Status
    output reg [14:0] pc_out,
    output reg core_reset_q,
    output reg irq
);
    reg [14:0] pc_q;
    reg [14:0] pc_d;
    reg [6:0] pc_high_latch_q;
    reg [7:0] working_q;
    reg [15:0] ptr0_q;
    reg [15:0] ptr1_q;
    reg fault_en_q;
    reg ovf_flag_q;
    reg unf_flag_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg [31:0] rd_word;

    // Register offset match, shared by every write strobe and select
    function reg_hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            reg_hit = (adr == ofs);
        end
    endfunction

    // Nine-bit branch operand widened to the counter with its sign
    function [14:0] sign_ext9;
        input [8:0] ofs;
        begin
            sign_ext9 = {{6{ofs[8]}}, ofs};
        end
    endfunction

    // Byte placed in an otherwise zero bus word
    function [31:0] zext8;
        input [7:0] v;
        begin
            zext8 = {24'h0, v};
        end
    endfunction

    wire [14:0] pc_inc = pc_q + 15'h0001;
    wire [14:0] bra_ofs = sign_ext9(op_operand[8:0]);

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire bus_rd = bus_req && !wb_we_i;
    wire ind0_sel = reg_hit(wb_adr_i, `REG_IND0);
    wire ind1_sel = reg_hit(wb_adr_i, `REG_IND1);

    // Write strobes, one per writable register
    wire wr_pc_low = bus_wr && reg_hit(wb_adr_i, `REG_PC_LOW);
    wire wr_latch = bus_wr && reg_hit(wb_adr_i, `REG_PC_HIGH_LATCH);
    wire wr_working = bus_wr && reg_hit(wb_adr_i, `REG_WORKING);
    wire wr_config = bus_wr && reg_hit(wb_adr_i, `REG_CONFIG);
    wire wr_ptr0 = bus_wr && reg_hit(wb_adr_i, `REG_PTR0);
    wire wr_ptr1 = bus_wr && reg_hit(wb_adr_i, `REG_PTR1);
    wire wr_pwr = bus_wr && reg_hit(wb_adr_i, `REG_PWR_STATUS);
    wire wr_irq_clr = bus_wr && reg_hit(wb_adr_i, `REG_IRQ_CLEAR);
    wire wr_irq_en = bus_wr && reg_hit(wb_adr_i, `REG_IRQ_ENABLE);

    // A low-byte write owns the counter, so the op of that cycle is
    // dropped whole and must not move the stack either
    wire op_live = op_valid && !wr_pc_low;
    wire is_call = op_live && (op_code == `OP_CALL ||
        op_code == `OP_CALL_WORKING || op_code == `OP_INTERRUPT);
    wire is_ret = op_live && (op_code == `OP_RETURN);

    wire [14:0] stk_top;
    wire stk_ovf;
    wire stk_unf;
    wire [4:0] stk_ptr;
    wire fault = stk_ovf || stk_unf;
    wire [2:0] irq_event = {fault, stk_unf, stk_ovf};

    return_stack #(.AW(15), .DEPTH_LOG2(4)) u_stack (
        .clk(clk),
        .rstn(rstn),
        .push(is_call),
        .pop(is_ret),
        .fault_en(fault_en_q),
        .push_data(pc_inc),
        .top_data(stk_top),
        .overflow(stk_ovf),
        .underflow(stk_unf),
        .ptr(stk_ptr)
    );

    wire [15:0] ind_ptr = ind1_sel ? ptr1_q : ptr0_q;
    wire [15:0] ind_maddr;
    wire ind_mrd;
    wire ind_mwr;
    wire [7:0] ind_mwdata;
    wire [7:0] ind_rdata;

    indirect_access u_ind (
        .pointer(ind_ptr),
        .rd(bus_rd && (ind0_sel || ind1_sel)),
        .wr(bus_wr && (ind0_sel || ind1_sel)),
        .wdata(wb_dat_i[7:0]),
        .mem_addr(ind_maddr),
        .mem_rd(ind_mrd),
        .mem_wr(ind_mwr),
        .mem_wdata(ind_mwdata),
        .mem_rdata(mem_rdata),
        .rdata(ind_rdata)
    );

    // Next program counter, one source per cycle
    always @* begin
        pc_d = pc_q;
        if (wr_pc_low) begin
            pc_d = {pc_high_latch_q, wb_dat_i[7:0]};
        end else if (op_valid) begin
            case (op_code)
                `OP_CALL: pc_d = {pc_high_latch_q[6:3],
                    op_operand};
                `OP_CALL_WORKING: pc_d = {pc_high_latch_q,
                    working_q};
                `OP_BRANCH_WORKING: pc_d = pc_inc + {7'h00,
                    working_q};
                `OP_BRANCH_IMM: pc_d = pc_inc + bra_ofs;
                `OP_RETURN: pc_d = stk_top;
                `OP_INTERRUPT: pc_d = 15'h0004;
                default: pc_d = pc_inc;
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= `PC_RESET;
            pc_out <= `PC_RESET;
            core_reset_q <= 1'b0;
        end else if (fault) begin
            pc_q <= `PC_RESET;
            pc_out <= `PC_RESET;
            core_reset_q <= 1'b1;
        end else begin
            pc_q <= pc_d;
            pc_out <= pc_d;
            core_reset_q <= 1'b0;
        end
    end

    // Page latch for the upper counter bits
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_high_latch_q <= 7'h00;
        end else if (wr_latch) begin
            pc_high_latch_q <= wb_dat_i[6:0];
        end
    end

    // Working register image used by the computed call and branch
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            working_q <= 8'h00;
        end else if (wr_working) begin
            working_q <= wb_dat_i[7:0];
        end
    end

    // File-select pointers, each a full sixteen-bit address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr0_q <= `PTR_RESET;
            ptr1_q <= `PTR_RESET;
        end else begin
            if (wr_ptr0) begin
                ptr0_q <= wb_dat_i[15:0];
            end
            if (wr_ptr1) begin
                ptr1_q <= wb_dat_i[15:0];
            end
        end
    end

    // Stack fault reset enable
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_en_q <= `CFG_RESET;
        end else if (wr_config) begin
            fault_en_q <= wb_dat_i[`CFG_FAULT_EN_BIT];
        end
    end

    // Fault flags: writing 0 clears a bit, a fault in that cycle wins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_flag_q <= 1'b0;
            unf_flag_q <= 1'b0;
        end else begin
            if (stk_ovf) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_pwr) begin
                ovf_flag_q <= ovf_flag_q & wb_dat_i[`PWR_OVF_BIT];
            end
            if (stk_unf) begin
                unf_flag_q <= 1'b1;
            end else if (wr_pwr) begin
                unf_flag_q <= unf_flag_q & wb_dat_i[`PWR_UNF_BIT];
            end
        end
    end

    // Sticky event bits; a new event wins over a clear
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_q <= 3'h0;
        end else if (wr_irq_clr) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[2:0]) | irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
    end

    // Interrupt enables, same layout as the status bits
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_q <= 3'h0;
        end else if (wr_irq_en) begin
            irq_en_q <= wb_dat_i[2:0];
        end
    end

    // Read data for the addressed register; unmapped offsets read zero
    always @* begin
        rd_word = 32'h00000000;
        case (wb_adr_i)
            `REG_PC_LOW: rd_word = zext8(pc_q[7:0]);
            `REG_PC_HIGH_LATCH: rd_word = {25'h0, pc_high_latch_q};
            `REG_PC_FULL: rd_word = {17'h0, pc_q};
            `REG_STACK_PTR: rd_word = {27'h0, stk_ptr};
            `REG_PWR_STATUS: rd_word = {30'h0, unf_flag_q,
                ovf_flag_q};
            `REG_CONFIG: rd_word = {31'h0, fault_en_q};
            `REG_PTR0: rd_word = {16'h0, ptr0_q};
            `REG_PTR1: rd_word = {16'h0, ptr1_q};
            `REG_IND0: rd_word = zext8(ind_rdata);
            `REG_IND1: rd_word = zext8(ind_rdata);
            `REG_IRQ_STATUS: rd_word = {29'h0, irq_stat_q};
            `REG_IRQ_ENABLE: rd_word = {29'h0, irq_en_q};
            `REG_WORKING: rd_word = zext8(working_q);
            default: rd_word = 32'h00000000;
        endcase
    end

    // Bus answer: one registered ack per request, data with it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_rd) begin
                wb_dat_o <= rd_word;
            end
        end
    end

    // Data memory strobes, one cycle behind the request edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_addr <= ind_maddr;
            mem_rd <= ind_mrd;
            mem_wr <= ind_mwr;
            mem_wdata <= ind_mwdata;
        end
    end

    // Level interrupt, high while an enabled status bit is set
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_en_q);
        end
    end
endmodule

// *** verification/pc_flow_properties.sv ***
// Purpose: Port assertions for pc_flow.
// Assumes: Ops arrive at least three cycles apart.
// Notes:   Bound from the bench file.
`timescale 1ns/1ps
`include "pc_flow_regs.vh"
module pc_flow_properties (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Bus handshake
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Instruction stream
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [10:0] op_operand,
    // Results
    input wire mem_rd,
    input wire mem_wr,
    input wire [14:0] pc_out,
    input wire core_reset_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ack_next:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    chk_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_seq_step:
        assert property (op_valid && op_code == `OP_NONE && !wb_cyc_i
            ##1 !op_valid |=> pc_out == $past(pc_out, 2) + 15'h1)
        else $error("sequential step wrong");
    chk_bra_target:
        assert property (op_valid && op_code == `OP_BRANCH_IMM && !wb_cyc_i
            ##1 !op_valid |=> pc_out == $past(pc_out, 2) + 15'h1
            + {{6{$past(op_operand[8], 2)}}, $past(op_operand[8:0], 2)})
        else $error("branch target wrong");
    chk_call_low:
        assert property (op_valid && op_code == `OP_CALL && !wb_cyc_i
            ##1 !op_valid |=> pc_out[10:0] == $past(op_operand, 2)
            || pc_out == 15'h0)
        else $error("call target wrong");
    chk_fault_pc:
        assert property (core_reset_q |-> ##[0:1] pc_out == 15'h0)
        else $error("fault reset left counter");
    chk_fault_pulse:
        assert property (core_reset_q |=> !core_reset_q)
        else $error("fault request too long");
    chk_mem_pulse:
        assert property (mem_rd || mem_wr |=> !mem_rd && !mem_wr)
        else $error("memory strobe too long");
    chk_mem_cause:
        assert property (mem_rd || mem_wr |-> wb_cyc_i && wb_stb_i)
        else $error("memory access without request");
endmodule

// *** verification/pc_flow_bench.sv ***
// Purpose: Self-checking bench for pc_flow.
// Assumes: Ops spaced so their effect has landed before sampling.
// Notes:   The stack is filled through interrupt ops.
`timescale 1ns/1ps
`include "pc_flow_regs.vh"
module pc_flow_bench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, op_valid = 1'b0;
    reg [7:0] adr = 8'h00, mem_rdata = 8'h00, wa = 8'h00, wd = 8'h00;
    reg [31:0] wdat = 32'h0, rd = 32'h0;
    reg [2:0] op_code = 3'h0;
    reg [10:0] op_operand = 11'h000;
    reg [7:0] rd_cnt = 8'h00, wr_cnt = 8'h00, fr_cnt = 8'h00;
    integer mismatches = 0, checked = 0, cycles = 0;
    wire [31:0] rdat;
    wire [15:0] mem_addr;
    wire [14:0] pc_out;
    wire [7:0] mem_wdata;
    wire ack, mem_rd, mem_wr, core_reset_q, irq;
    pc_flow u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pc_out(pc_out),
        .core_reset_q(core_reset_q), .irq(irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (mem_rd) rd_cnt <= rd_cnt + 8'h01;
        if (core_reset_q) fr_cnt <= fr_cnt + 8'h01;
        if (mem_wr) begin
            wr_cnt <= wr_cnt + 8'h01;
            wa <= mem_addr[7:0];
            wd <= mem_wdata;
        end
        if (cycles == 6000) begin
            mismatches = mismatches + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time,
                    seen, exp);
            end
        end
    endtask
    task bus(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk);
            while (ack !== 1'b1) begin
                @(posedge clk);
            end
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            bus(a, 1'b0, 32'h0);
            check(rd, exp);
        end
    endtask
    task op(input [2:0] c, input [10:0] o);
        begin
            @(posedge clk);
            op_valid <= 1'b1;
            op_code <= c;
            op_operand <= o;
            @(posedge clk);
            op_valid <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task pcchk(input [31:0] exp);
        check({17'h0, pc_out}, exp);
    endtask
    task rst;
        begin
            rstn <= 1'b0;
            repeat (6) @(posedge clk);
            rstn <= 1'b1;
        end
    endtask
    initial begin
        rst;
        pcchk(32'h0);
        rdchk(`REG_STACK_PTR, 32'h1F);
        rdchk(8'h3C, 32'h0);
        wr(`REG_PC_HIGH_LATCH, 32'h55);
        wr(`REG_PC_LOW, 32'hA3);
        rdchk(`REG_PC_FULL, 32'h55A3);
        rdchk(`REG_PC_LOW, 32'hA3);
        op(`OP_NONE, 11'h000);
        pcchk(32'h55A4);
        wr(`REG_PC_HIGH_LATCH, 32'h7F);
        wr(`REG_PC_LOW, 32'hFF);
        op(`OP_NONE, 11'h000);
        pcchk(32'h0);
        wr(`REG_PC_HIGH_LATCH, 32'h55);
        op(`OP_CALL, 11'h3C5);
        pcchk(32'h53C5);
        wr(`REG_WORKING, 32'h34);
        op(`OP_CALL_WORKING, 11'h000);
        pcchk(32'h5534);
        wr(`REG_WORKING, 32'hF0);
        op(`OP_BRANCH_WORKING, 11'h000);
        pcchk(32'h5625);
        op(`OP_BRANCH_IMM, 11'h1F0);
        pcchk(32'h5616);
        $display("test counter loads done");
        rst;
        repeat (17) op(`OP_INTERRUPT, 11'h000);
        rdchk(`REG_STACK_PTR, 32'h0);
        check({24'h0, fr_cnt}, 32'h0);
        op(`OP_RETURN, 11'h000);
        pcchk(32'h5);
        $display("test stack wrap done");
        rst;
        wr(`REG_CONFIG, 32'h1);
        wr(`REG_IRQ_ENABLE, 32'h5);
        repeat (17) op(`OP_INTERRUPT, 11'h000);
        check({24'h0, fr_cnt}, 32'h1);
        pcchk(32'h0);
        rdchk(`REG_STACK_PTR, 32'h0F);
        rdchk(`REG_PWR_STATUS, 32'h1);
        rdchk(`REG_IRQ_STATUS, 32'h5);
        check({31'h0, irq}, 32'h1);
        wr(`REG_IRQ_CLEAR, 32'h5);
        wr(`REG_IRQ_ENABLE, 32'h1);
        repeat (16) op(`OP_RETURN, 11'h000);
        pcchk(32'h1);
        op(`OP_RETURN, 11'h000);
        rdchk(`REG_IRQ_STATUS, 32'h6);
        check({31'h0, irq}, 32'h0);
        rdchk(`REG_PWR_STATUS, 32'h3);
        wr(`REG_PWR_STATUS, 32'h0);
        rdchk(`REG_PWR_STATUS, 32'h0);
        $display("test stack fault done");
        mem_rdata <= 8'h5A;
        wr(`REG_PTR0, 32'h1234);
        rdchk(`REG_PTR0, 32'h1234);
        rdchk(`REG_IND0, 32'h5A);
        wr(`REG_IND0, 32'h77);
        @(posedge clk);
        check({wa, wd}, 32'h3477);
        wr(`REG_PTR1, 32'h1);
        rdchk(`REG_IND1, 32'h0);
        wr(`REG_IND1, 32'h66);
        wr(`REG_PTR0, 32'h0);
        rdchk(`REG_IND0, 32'h0);
        check({rd_cnt, wr_cnt}, 32'h0101);
        $display("test indirect done");
        tally_and_finish;
    end
endmodule
bind pc_flow pc_flow_properties u_chk (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .pc_out(pc_out),
    .core_reset_q(core_reset_q));
